// ### timer_ctrl_event_irq_regs.sv
// Control, event and interrupt registers of a 16-bit timer in normal mode, APB slave.
// Assumes the counting core runs on pclk and supplies counter value, UPDATE and TOP/BOTTOM
// strobes; only the event input arrives from another domain.
`default_nettype none

module timer_ctrl_event_irq_regs (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counting core.
  input wire logic [15:0] counter_value,
  input wire logic update_cond,
  input wire logic top_hit,
  input wire logic bottom_hit,
  input wire logic prescale_tick,
  input wire logic event_in,
  // Controls toward the core.
  output logic [15:0] period_value,
  output logic [2:0][15:0] match_value,
  output logic count_step,
  output logic count_dir,
  output logic force_restart,
  output logic force_hard_reset,
  output logic irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == {idx[5:0], 2'b00});
  endfunction

  logic wr;
  logic [7:0] wb;
  logic [1:0] cmd;
  logic upd;
  logic enable_r;
  logic [2:0] wave_r;
  timer_regs_pkg::ctrl_e_s ctrl_r;
  timer_regs_pkg::event_ctrl_s evc_r;
  logic [7:0] int_en_r;
  logic [7:0] flags_r;
  logic [7:0] flag_set;
  logic [2:0] match_hit;
  logic [3:0] bv_r;
  logic [3:0] bv_set;
  logic [15:0] period_buffer_r;
  logic [2:0][15:0] cmpbuf_r;
  logic ev_meta_r;
  logic ev_sync_r;
  logic ev_prev_r;
  logic step_nxt;
  logic [31:0] rdata_nxt;
  logic mapped;

  // Writes take effect at the access edge; reads are captured in the setup cycle.
  assign wr = psel & penable & pwrite;
  assign wb = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign pready = 1'b1;
  assign cmd = (wr && hit(paddr, timer_regs_pkg::IDX_CTRL_E_SET)) ?
               wb[timer_regs_pkg::CMD_LSB +: 2] : 2'b00;
  // A software forced update bypasses the lock.
  assign upd = (update_cond & ~ctrl_r.update_lock) |
               (cmd == timer_regs_pkg::CMD_UPDATE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= 1'b0;
      wave_r <= 3'h0;
      evc_r <= '0;
      int_en_r <= timer_regs_pkg::REG8_RESET;
    end else if (wr && pstrb[0]) begin
      if (hit(paddr, timer_regs_pkg::IDX_ENABLE)) enable_r <= pwdata[0];
      if (hit(paddr, timer_regs_pkg::IDX_WAVE)) wave_r <= pwdata[2:0];
      if (hit(paddr, timer_regs_pkg::IDX_EVENT)) evc_r <= pwdata[3:0];
      if (hit(paddr, timer_regs_pkg::IDX_INT_EN)) begin
        int_en_r <= pwdata[7:0] & timer_regs_pkg::INT_MASK;
      end
    end
  end

  // Commands are one-cycle strobes; a hard reset is dropped while the timer runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_restart <= 1'b0;
      force_hard_reset <= 1'b0;
    end else begin
      force_restart <= (cmd == timer_regs_pkg::CMD_RESTART);
      force_hard_reset <= (cmd == timer_regs_pkg::CMD_HARD_RESET) & ~enable_r;
    end
  end

  // Event input synchroniser and edge history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_meta_r <= 1'b0;
      ev_sync_r <= 1'b0;
      ev_prev_r <= 1'b0;
    end else begin
      ev_meta_r <= event_in;
      ev_sync_r <= ev_meta_r;
      ev_prev_r <= ev_sync_r;
    end
  end

  always_comb begin
    step_nxt = 1'b0;
    if (evc_r.event_count_enable) begin
      case (evc_r.event_action)
        timer_regs_pkg::EV_RISING: step_nxt = ev_sync_r & ~ev_prev_r;
        timer_regs_pkg::EV_ANY_EDGE: step_nxt = ev_sync_r ^ ev_prev_r;
        timer_regs_pkg::EV_HIGH_LEVEL: step_nxt = prescale_tick & ev_sync_r;
        timer_regs_pkg::EV_DIRECTION: step_nxt = prescale_tick;
        default: step_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) count_step <= 1'b0;
    else count_step <= step_nxt;
  end

  // One storage bit serves both the set and clear views. Hardware direction changes
  // win over software in the same cycle, since they reflect the core's real state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
    end else begin
      if (wr && hit(paddr, timer_regs_pkg::IDX_CTRL_E_SET)) begin
        ctrl_r <= ctrl_r | wb[1:0];
      end else if (wr && hit(paddr, timer_regs_pkg::IDX_CTRL_E_CLR)) begin
        ctrl_r <= ctrl_r & ~wb[1:0];
      end
      if (evc_r.event_count_enable && evc_r.event_action == timer_regs_pkg::EV_DIRECTION &&
          prescale_tick) begin
        ctrl_r.dir <= ev_sync_r;
      end else if (wave_r >= timer_regs_pkg::WG_DS_TOP && top_hit) begin
        ctrl_r.dir <= 1'b1;
      end else if (wave_r >= timer_regs_pkg::WG_DS_TOP && bottom_hit) begin
        ctrl_r.dir <= 1'b0;
      end
    end
  end
  assign count_dir = ctrl_r.dir;

  // Buffer writes; a buffer write in the UPDATE cycle keeps its valid bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_buffer_r <= timer_regs_pkg::PERIOD_RESET;
      period_value <= timer_regs_pkg::PERIOD_RESET;
    end else begin
      if (upd) period_value <= period_buffer_r;
      if (wr && hit(paddr, timer_regs_pkg::IDX_PERIOD_BUFFER)) begin
        if (pstrb[0]) period_buffer_r[7:0] <= pwdata[7:0];
        if (pstrb[1]) period_buffer_r[15:8] <= pwdata[15:8];
      end
    end
  end
  assign bv_set[timer_regs_pkg::PERIOD_BUFFER_VALID_BIT] = wr & hit(paddr, timer_regs_pkg::IDX_PERIOD_BUFFER);

  genvar n;
  generate
    for (n = 0; n < 3; n++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmpbuf_r[n] <= timer_regs_pkg::MATCH_RESET;
          match_value[n] <= timer_regs_pkg::MATCH_RESET;
        end else begin
          if (upd) match_value[n] <= cmpbuf_r[n];
          if (wr && hit(paddr, timer_regs_pkg::IDX_CMPBUF0 + 8'(2 * n))) begin
            if (pstrb[0]) cmpbuf_r[n][7:0] <= pwdata[7:0];
            if (pstrb[1]) cmpbuf_r[n][15:8] <= pwdata[15:8];
          end
        end
      end
      assign bv_set[timer_regs_pkg::CMPBV_LSB + n] =
        wr & hit(paddr, timer_regs_pkg::IDX_CMPBUF0 + 8'(2 * n));
      assign match_hit[n] = (counter_value == match_value[n]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bv_r <= 4'h0;
    end else begin
      if (upd) begin
        bv_r <= bv_set;
      end else if (wr && hit(paddr, timer_regs_pkg::IDX_BV_SET)) begin
        bv_r <= bv_r | wb[3:0] | bv_set;
      end else if (wr && hit(paddr, timer_regs_pkg::IDX_BV_CLR)) begin
        bv_r <= (bv_r & ~wb[3:0]) | bv_set;
      end else begin
        bv_r <= bv_r | bv_set;
      end
    end
  end

  // Which end of the count raises the wrap flag depends on the waveform mode.
  always_comb begin
    flag_set = 8'h00;
    // All flag sources meet in this one process, so no bit has a second driver.
    flag_set[timer_regs_pkg::MATCH_LSB +: 3] = match_hit;
    case (wave_r)
      timer_regs_pkg::WG_NORMAL, timer_regs_pkg::WG_FREQ, timer_regs_pkg::WG_DS_TOP:
        flag_set[timer_regs_pkg::WRAP_BIT] = top_hit;
      timer_regs_pkg::WG_SINGLE, timer_regs_pkg::WG_DS_BOTTOM:
        flag_set[timer_regs_pkg::WRAP_BIT] = bottom_hit;
      timer_regs_pkg::WG_DS_BOTH:
        flag_set[timer_regs_pkg::WRAP_BIT] = top_hit | bottom_hit;
      default: flag_set[timer_regs_pkg::WRAP_BIT] = 1'b0;
    endcase
  end

  // Flags only clear by a written one, and a new event in that cycle still sets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= timer_regs_pkg::REG8_RESET;
    end else if (wr && hit(paddr, timer_regs_pkg::IDX_INT_FLAGS)) begin
      flags_r <= ((flags_r & ~wb) | flag_set) & timer_regs_pkg::INT_MASK;
    end else begin
      flags_r <= (flags_r | flag_set) & timer_regs_pkg::INT_MASK;
    end
  end

  assign irq = |(flags_r & int_en_r);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(paddr, timer_regs_pkg::IDX_ENABLE)) rdata_nxt[0] = enable_r;
    else if (hit(paddr, timer_regs_pkg::IDX_WAVE)) rdata_nxt[2:0] = wave_r;
    else if (hit(paddr, timer_regs_pkg::IDX_CTRL_E_CLR) ||
             hit(paddr, timer_regs_pkg::IDX_CTRL_E_SET)) rdata_nxt[1:0] = ctrl_r;
    else if (hit(paddr, timer_regs_pkg::IDX_BV_CLR) ||
             hit(paddr, timer_regs_pkg::IDX_BV_SET)) rdata_nxt[3:0] = bv_r;
    else if (hit(paddr, timer_regs_pkg::IDX_EVENT)) rdata_nxt[3:0] = evc_r;
    else if (hit(paddr, timer_regs_pkg::IDX_INT_EN)) rdata_nxt[7:0] = int_en_r;
    else if (hit(paddr, timer_regs_pkg::IDX_INT_FLAGS)) rdata_nxt[7:0] = flags_r;
    else if (hit(paddr, timer_regs_pkg::IDX_PERIOD)) rdata_nxt[15:0] = period_value;
    else if (hit(paddr, timer_regs_pkg::IDX_PERIOD_BUFFER)) rdata_nxt[15:0] = period_buffer_r;
    else if (hit(paddr, timer_regs_pkg::IDX_MATCH0)) rdata_nxt[15:0] = match_value[0];
    else if (hit(paddr, timer_regs_pkg::IDX_MATCH0 + 8'h02)) rdata_nxt[15:0] = match_value[1];
    else if (hit(paddr, timer_regs_pkg::IDX_MATCH0 + 8'h04)) rdata_nxt[15:0] = match_value[2];
    else if (hit(paddr, timer_regs_pkg::IDX_CMPBUF0)) rdata_nxt[15:0] = cmpbuf_r[0];
    else if (hit(paddr, timer_regs_pkg::IDX_CMPBUF0 + 8'h02)) rdata_nxt[15:0] = cmpbuf_r[1];
    else if (hit(paddr, timer_regs_pkg::IDX_CMPBUF0 + 8'h04)) rdata_nxt[15:0] = cmpbuf_r[2];
    else mapped = 1'b0;
  end

  // Read data and error are registered in the setup cycle, so the access has no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= ~mapped;
    end
  end

endmodule

`default_nettype wire

// ### timer_regs_pkg.sv
// Constants and carrier types for the timer control, event and interrupt register block.
// Assumes a 32-bit APB bus where each 8-bit or 16-bit register sits in one aligned word.
// How it works
// - Set-style writes of one set bits
// - Clear-style writes of one clear bits
// - Command field: none, update, restart, hard reset
// - Command field always reads back zero
// - Hard reset ignored while timer enabled
// - Unlocked: UPDATE loads buffers into registers
// - Locked: UPDATE transfers nothing
// - Forced update command ignores the lock
// - Direction zero counts up, one down
// - Hardware drives direction, software may write
// - Compare buffer write sets its valid bit
// - Period buffer write sets its valid bit
// - UPDATE clears valid bits of buffers not written in that cycle
// - Action 0 rising edges, 1 any edge
// - Action 2 counts ticks while event high
// - Action 3 counts ticks, event sets direction
// - Counting on events only when enabled
// - Per-channel compare interrupt enables, bits 4-6
// - Overflow interrupt enable at bit 0
// - Compare flag set on counter match
// - Overflow flag on TOP or BOTTOM per mode
// - Flags clear only by writing one
// - Permitted UPDATE loads compare from its buffer
`default_nettype none

package timer_regs_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_ENABLE = 8'h00;
  localparam logic [7:0] IDX_WAVE = 8'h01;
  localparam logic [7:0] IDX_CTRL_E_CLR = 8'h04;
  localparam logic [7:0] IDX_CTRL_E_SET = 8'h05;
  localparam logic [7:0] IDX_BV_CLR = 8'h06;
  localparam logic [7:0] IDX_BV_SET = 8'h07;
  localparam logic [7:0] IDX_EVENT = 8'h09;
  localparam logic [7:0] IDX_INT_EN = 8'h0a;
  localparam logic [7:0] IDX_INT_FLAGS = 8'h0b;
  localparam logic [7:0] IDX_PERIOD = 8'h26;
  localparam logic [7:0] IDX_MATCH0 = 8'h28;
  localparam logic [7:0] IDX_PERIOD_BUFFER = 8'h36;
  localparam logic [7:0] IDX_CMPBUF0 = 8'h38;
  localparam logic [7:0] IDX_STEP = 8'h02;

  // Field positions.
  localparam int DIR_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int CMD_LSB = 2;
  localparam int WRAP_BIT = 0;
  localparam int MATCH_LSB = 4;
  localparam int PERIOD_BUFFER_VALID_BIT = 0;
  localparam int CMPBV_LSB = 1;
  localparam logic [7:0] INT_MASK = 8'h71;

  // Values after reset.
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [7:0] REG8_RESET = 8'h00;

  typedef enum logic [1:0] {
    CMD_NONE, CMD_UPDATE, CMD_RESTART, CMD_HARD_RESET
  } command_e;

  typedef enum logic [2:0] {
    EV_RISING, EV_ANY_EDGE, EV_HIGH_LEVEL, EV_DIRECTION
  } event_action_e;

  typedef enum logic [2:0] {
    WG_NORMAL, WG_FREQ, WG_RSV2, WG_SINGLE, WG_RSV4, WG_DS_TOP, WG_DS_BOTH, WG_DS_BOTTOM
  } waveform_e;

  typedef struct packed {
    logic [2:0] event_action;
    logic event_count_enable;
  } event_ctrl_s;

  typedef struct packed {
    logic update_lock;
    logic dir;
  } ctrl_e_s;

endpackage

`default_nettype wire

// ### timer_regs_asserts.sv
// Port-level assertions for the timer control, event and interrupt register block.
// Assumes one pclk domain and is bound to the top module from tb_top.
`default_nettype none

module timer_regs_asserts (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0] pstrb,
  // Core side.
  input wire logic [15:0] counter_value,
  input wire logic [15:0] period_value,
  input wire logic update_cond,
  input wire logic top_hit,
  input wire logic bottom_hit,
  input wire logic prescale_tick,
  input wire logic event_in,
  input wire logic [2:0][15:0] match_value,
  input wire logic count_step,
  input wire logic count_dir,
  input wire logic force_restart,
  input wire logic force_hard_reset,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic cmd_wr;
  assign wr = psel && penable && pwrite;
  assign cmd_wr = wr && paddr == 8'h14 && pstrb[0];
  a_cmd_reads_zero: assert property (
    psel && penable && !pwrite && paddr == 8'h14 |-> prdata[3:2] == 2'b00)
    else $error("command field read back nonzero");
  a_restart_pulse: assert property (
    cmd_wr && pwdata[3:2] == 2'b10 |=> force_restart ##1 !force_restart)
    else $error("restart pulse missing or too long");
  a_restart_cause: assert property (
    force_restart |-> $past(cmd_wr && pwdata[3:2] == 2'b10))
    else $error("restart pulse without command");
  a_hard_reset_cause: assert property (
    force_hard_reset |-> $past(cmd_wr && pwdata[3:2] == 2'b11))
    else $error("hard reset pulse without command");
  a_buffer_load_src: assert property (
    !$stable({period_value, match_value}) |->
    $past(update_cond || (cmd_wr && pwdata[3:2] != 2'b00) || force_hard_reset))
    else $error("active period or compare changed without update");
  a_flags_sticky: assert property (
    irq && !wr && !force_hard_reset |=> irq)
    else $error("request dropped without a write");
  a_dir_set: assert property (
    cmd_wr && pwdata[0] && !prescale_tick && !top_hit && !bottom_hit |=> count_dir)
    else $error("direction not set by set-style write");
  a_dir_clear: assert property (
    wr && paddr == 8'h10 && pstrb[0] && pwdata[0] && !prescale_tick && !top_hit
    |=> !count_dir)
    else $error("direction not cleared by clear-style write");
  a_step_cause: assert property (
    count_step |-> $past(prescale_tick) || $past(prescale_tick, 2) ||
    $past(event_in, 2) != $past(event_in, 3) || $past(event_in, 3) != $past(event_in, 4) ||
    $past(event_in, 4) != $past(event_in, 5))
    else $error("count step without event or tick");
  c_restart: cover property (force_restart);
  c_step: cover property (count_step);
  c_irq: cover property ($rose(irq));
endmodule

`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the timer register block, driving APB and core strobes.
// Assumes the design answers with zero wait states but waits on pready anyway.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, bottom_hit, event_in, pready, pslverr;
  logic update_cond, top_hit, prescale_tick, count_step, count_dir, irq;
  logic force_restart, force_hard_reset;
  logic [2:0] strb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] counter_value, period_value;
  logic [2:0][15:0] match_value;
  logic [7:0] regs [6] = '{8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b};
  logic [7:0] evs [6] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h02, 8'h09};
  int ev_exp [6] = '{1, 2, 2, 3, 0, 0};
  int failures, samples_checked, steps, restarts, hard_resets, n0;
  assign {top_hit, update_cond, prescale_tick} = strb;

  timer_ctrl_event_irq_regs i_timer_ctrl_event_irq_regs (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .counter_value(counter_value),
    .update_cond(update_cond),
    .top_hit(top_hit),
    .bottom_hit(bottom_hit),
    .prescale_tick(prescale_tick),
    .event_in(event_in),
    .period_value(period_value),
    .match_value(match_value),
    .count_step(count_step),
    .count_dir(count_dir),
    .force_restart(force_restart),
    .force_hard_reset(force_hard_reset),
    .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    steps += int'(count_step === 1'b1);
    restarts += int'(force_restart === 1'b1);
    hard_resets += int'(force_hard_reset === 1'b1);
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Every transfer waits on pready, so a slower slave would still be honoured.
  task automatic apb(logic [7:0] idx, logic wr, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(string what, logic [7:0] idx, logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_n(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic pulse(logic [2:0] m);
    @(posedge pclk);
    strb <= m;
    @(posedge pclk);
    strb <= 3'h0;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #50us;
    failures++;
    $display("watchdog expired");
    end_of_test;
  end

  initial begin
    {presetn, psel, penable, pwrite, bottom_hit, event_in, strb} = '0;
    {paddr, pwdata} = '0;
    pstrb = 4'hf;
    counter_value = 16'h7777;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rdchk("reset value", regs[i], 32'h0);
    chk("period reset", 32'h0000ffff, 32'(period_value));
    apb(8'h10, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, 32'(pslverr));
    $display("test reset done");
    apb(8'h00, 1'b1, 32'h1);
    apb(8'h05, 1'b1, 32'hc);
    wait_n(3);
    chk("hard reset while on", 32'h0, 32'(hard_resets));
    apb(8'h00, 1'b1, 32'h0);
    apb(8'h05, 1'b1, 32'hc);
    apb(8'h05, 1'b1, 32'h8);
    wait_n(3);
    chk("hard reset", 32'h1, 32'(hard_resets));
    chk("restart", 32'h1, 32'(restarts));
    apb(8'h05, 1'b1, 32'h3);
    rdchk("ctrl set", 8'h05, 32'h3);
    chk("dir down", 32'h1, 32'(count_dir));
    apb(8'h04, 1'b1, 32'h1);
    apb(8'h05, 1'b1, 32'h8);
    rdchk("ctrl after clear", 8'h05, 32'h2);
    $display("test control done");
    apb(8'h36, 1'b1, 32'h1234);
    for (int i = 0; i < 3; i++) apb(8'h38 + 8'(2 * i), 1'b1, 32'h10 * (i + 1));
    rdchk("buffer valid", 8'h07, 32'hf);
    pulse(3'b010);
    wait_n(1);
    chk("locked period", 32'hffff, 32'(period_value));
    apb(8'h05, 1'b1, 32'h4);
    wait_n(1);
    chk("forced period", 32'h1234, 32'(period_value));
    chk("forced match2", 32'h30, 32'(match_value[2]));
    rdchk("valid cleared", 8'h06, 32'h0);
    apb(8'h04, 1'b1, 32'h2);
    apb(8'h36, 1'b1, 32'h5678);
    pulse(3'b010);
    wait_n(1);
    chk("unlocked period", 32'h5678, 32'(period_value));
    apb(8'h07, 1'b1, 32'h5);
    apb(8'h06, 1'b1, 32'h1);
    rdchk("valid set clear", 8'h07, 32'h4);
    $display("test buffers done");
    apb(8'h0a, 1'b1, 32'hff);
    rdchk("int enable", 8'h0a, 32'h71);
    pstrb <= 4'h0;
    apb(8'h0a, 1'b1, 32'h0);
    pstrb <= 4'hf;
    rdchk("int enable kept", 8'h0a, 32'h71);
    pulse(3'b100);
    wait_n(1);
    chk("irq wrap", 32'h1, 32'(irq));
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      counter_value <= 16'h10 * 16'(i + 1);
      @(posedge pclk);
      counter_value <= 16'h7777;
      rdchk("flags", 8'h0b, 32'h1 | (((32'h2 << i) - 1) << 4));
    end
    apb(8'h0b, 1'b1, 32'h0);
    wait_n(5);
    rdchk("flags kept", 8'h0b, 32'h71);
    apb(8'h0a, 1'b1, 32'h0);
    wait_n(1);
    chk("irq masked", 32'h0, 32'(irq));
    apb(8'h0b, 1'b1, 32'h71);
    rdchk("flags cleared", 8'h0b, 32'h0);
    apb(8'h01, 1'b1, 32'h6);
    @(posedge pclk);
    bottom_hit <= 1'b1;
    @(posedge pclk);
    bottom_hit <= 1'b0;
    rdchk("bottom wrap", 8'h0b, 32'h1);
    pulse(3'b100);
    wait_n(1);
    chk("top turns down", 32'h1, 32'(count_dir));
    apb(8'h0b, 1'b1, 32'h1);
    apb(8'h01, 1'b1, 32'h0);
    rdchk("wrap cleared", 8'h0b, 32'h0);
    $display("test interrupts done");
    foreach (evs[i]) begin
      apb(8'h09, 1'b1, 32'(evs[i]));
      n0 = steps;
      @(posedge pclk);
      event_in <= 1'b1;
      wait_n(4);
      pulse(3'b001);
      pulse(3'b001);
      wait_n(4);
      if (evs[i] == 8'h07) chk("dir high", 32'h1, 32'(count_dir));
      @(posedge pclk);
      event_in <= 1'b0;
      wait_n(4);
      pulse(3'b001);
      wait_n(5);
      if (evs[i] == 8'h07) chk("dir low", 32'h0, 32'(count_dir));
      chk("event steps", 32'(ev_exp[i]), 32'(steps - n0));
    end
    $display("test events done");
    end_of_test;
  end
endmodule

bind timer_ctrl_event_irq_regs timer_regs_asserts i_timer_regs_asserts (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .pslverr(pslverr),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pstrb(pstrb),
  .counter_value(counter_value),
  .period_value(period_value),
  .update_cond(update_cond),
  .top_hit(top_hit),
  .bottom_hit(bottom_hit),
  .prescale_tick(prescale_tick),
  .event_in(event_in),
  .match_value(match_value),
  .count_step(count_step),
  .count_dir(count_dir),
  .force_restart(force_restart),
  .force_hard_reset(force_hard_reset),
  .irq(irq)
);

`default_nettype wire
